// File: src/win_blank_pkg.sv
// register map, field layouts and reset values of the readout window and blanking set
// assumes a 16-bit register port decoded from the serial control engine
package win_blank_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 16;

  // ----------------------------------------------------------------
  // register addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CHIP_VERSION     = 8'h00;
  localparam logic [7:0] ADDR_CHIP_VERSION_ALT = 8'hff;
  localparam logic [7:0] ADDR_COLUMN_START     = 8'h01;
  localparam logic [7:0] ADDR_ROW_START        = 8'h02;
  localparam logic [7:0] ADDR_WINDOW_HEIGHT    = 8'h03;
  localparam logic [7:0] ADDR_WINDOW_WIDTH     = 8'h04;
  localparam logic [7:0] ADDR_HORIZ_BLANK      = 8'h05;
  localparam logic [7:0] ADDR_VERT_BLANK       = 8'h06;

  // ----------------------------------------------------------------
  // field widths
  // ----------------------------------------------------------------
  localparam int unsigned COL_W   = 10;
  localparam int unsigned ROW_W   = 9;
  localparam int unsigned HGT_W   = 9;
  localparam int unsigned WID_W   = 10;
  localparam int unsigned HBLK_W  = 10;
  localparam int unsigned VBLK_W  = 15;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [9:0]  RST_COLUMN_START  = 10'h001;
  localparam logic [8:0]  RST_ROW_START     = 9'h004;
  localparam logic [8:0]  RST_WINDOW_HEIGHT = 9'h1e0;
  localparam logic [9:0]  RST_WINDOW_WIDTH  = 10'h2f0;
  localparam logic [9:0]  RST_HORIZ_BLANK   = 10'h05e;
  localparam logic [14:0] RST_VERT_BLANK    = 15'h002d;

  // arbitrary neutral identity value
  localparam logic [15:0] VERSION_DEFAULT   = 16'h5a01;

  localparam logic [15:0] DATA_ZERO         = 16'h0000;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [COL_W-1:0]  column_start;
    logic [ROW_W-1:0]  row_start;
    logic [HGT_W-1:0]  window_height;
    logic [WID_W-1:0]  window_width;
    logic [HBLK_W-1:0] horizontal_blanking;
    logic [VBLK_W-1:0] vertical_blanking;
  } window_cfg_t;

  localparam window_cfg_t CFG_RESET = '{
    column_start:        RST_COLUMN_START,
    row_start:           RST_ROW_START,
    window_height:       RST_WINDOW_HEIGHT,
    window_width:        RST_WINDOW_WIDTH,
    horizontal_blanking: RST_HORIZ_BLANK,
    vertical_blanking:   RST_VERT_BLANK
  };

  typedef struct packed {
    logic              wr_en;
    logic              rd_en;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } reg_req_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_ARMED = 2'b01
  } xfer_state_t;

endpackage

// File: src/shadow_field.sv
// one double-buffered field: pending copy written by the host, live copy loaded at frame start
// assumes the caller decodes the write strobe and supplies the frame-start pulse
`timescale 1ns/1ns

module shadow_field
  import win_blank_pkg::*;
#(
  parameter int unsigned          W         = 10,
  parameter logic [W-1:0]         RST_VALUE = '0
)
(
  input  wire logic         clock_i,
  input  wire logic         rst_b_i,
  input  wire logic         wr_i,
  input  wire logic [W-1:0] wdata_i,
  input  wire logic         load_i,
  output logic      [W-1:0] pending_o,
  output logic      [W-1:0] live_o
);

  logic [W-1:0] pending_ff;
  logic [W-1:0] live_ff;

  // ----------------------------------------------------------------
  // pending copy
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i)
  begin
    if (!rst_b_i)
      pending_ff <= RST_VALUE;
    else if (wr_i)
      pending_ff <= wdata_i; // R10
  end

  // ----------------------------------------------------------------
  // live copy
  // ----------------------------------------------------------------
  // a write in the same cycle as frame start lands in pending only and
  // goes live at the next frame start, so a frame never sees a half update
  always_ff @(posedge clock_i)
  begin
    if (!rst_b_i)
      live_ff <= RST_VALUE;
    else if (load_i)
      live_ff <= pending_ff; // R9
  end

  assign pending_o = pending_ff;
  assign live_o    = live_ff;

endmodule

// File: src/readout_window_blanking_regs.sv
// readout window and blanking registers with pending and live copies
// assumes the serial control engine presents one-cycle read/write strobes
// and the timing generator pulses frame_start_i at the first dark row
//
// How it works
// R1: column start is 10 bits, first image column after dark columns, 1 to 752.
// R2: row start is 9 bits, first image row after dark rows, resets to 4.
// R3: host should not set row start below four; dark rows use another control.
// R4: window height gives image rows read out, 1 to 480, resets to 0x1e0.
// R5: window width gives image columns read out, 1 to 752, resets to 0x2f0.
// R6: horizontal blanking columns per row, host keeps 43 to 1023, resets 0x05e.
// R7: vertical blanking rows per frame, 15 bits, host keeps 4 to 3000, reset 0x002d.
// R8: undefined bits are read-only; writes to them change nothing.
// R9: pending values copy to live copies at frame start.
// R10: bus reads and writes touch only pending copies; live copies drive the sensor.
// R11: host writes only legal values; out-of-range behaviour is undefined.
`timescale 1ns/1ns

module readout_window_blanking_regs
  import win_blank_pkg::*;
#(
  parameter logic [15:0] VERSION_ID = VERSION_DEFAULT // arbitrary value
)
(
  input  wire logic              clock_i,
  input  wire logic              rst_b_i,
  input  wire reg_req_t          req_i,
  output logic      [DATA_W-1:0] rdata_o,
  output logic                   rvalid_o,
  input  wire logic              frame_start_i,
  output window_cfg_t            live_cfg_o,
  output logic                   cfg_loaded_o
);

  // ----------------------------------------------------------------
  // write decode
  // ----------------------------------------------------------------
  logic wr_col;
  logic wr_row;
  logic wr_hgt;
  logic wr_wid;
  logic wr_hblk;
  logic wr_vblk;

  assign wr_col  = req_i.wr_en && (req_i.addr == ADDR_COLUMN_START);
  assign wr_row  = req_i.wr_en && (req_i.addr == ADDR_ROW_START);
  assign wr_hgt  = req_i.wr_en && (req_i.addr == ADDR_WINDOW_HEIGHT);
  assign wr_wid  = req_i.wr_en && (req_i.addr == ADDR_WINDOW_WIDTH);
  assign wr_hblk = req_i.wr_en && (req_i.addr == ADDR_HORIZ_BLANK);
  assign wr_vblk = req_i.wr_en && (req_i.addr == ADDR_VERT_BLANK);

  // ----------------------------------------------------------------
  // shadowed fields
  // ----------------------------------------------------------------
  // only the defined low bits are stored; upper data bits are dropped here
  window_cfg_t pend_cfg;
  window_cfg_t live_cfg;

  shadow_field #(.W(COL_W), .RST_VALUE(RST_COLUMN_START)) u_col
  (
    .clock_i   (clock_i),
    .rst_b_i   (rst_b_i),
    .wr_i      (wr_col),
    .wdata_i   (req_i.wdata[COL_W-1:0]), // R1 R8
    .load_i    (frame_start_i),
    .pending_o (pend_cfg.column_start),
    .live_o    (live_cfg.column_start)
  );

  shadow_field #(.W(ROW_W), .RST_VALUE(RST_ROW_START)) u_row
  (
    .clock_i   (clock_i),
    .rst_b_i   (rst_b_i),
    .wr_i      (wr_row),
    .wdata_i   (req_i.wdata[ROW_W-1:0]), // R2 R8
    .load_i    (frame_start_i),
    .pending_o (pend_cfg.row_start),
    .live_o    (live_cfg.row_start)
  );

  shadow_field #(.W(HGT_W), .RST_VALUE(RST_WINDOW_HEIGHT)) u_hgt
  (
    .clock_i   (clock_i),
    .rst_b_i   (rst_b_i),
    .wr_i      (wr_hgt),
    .wdata_i   (req_i.wdata[HGT_W-1:0]), // R4 R8
    .load_i    (frame_start_i),
    .pending_o (pend_cfg.window_height),
    .live_o    (live_cfg.window_height)
  );

  shadow_field #(.W(WID_W), .RST_VALUE(RST_WINDOW_WIDTH)) u_wid
  (
    .clock_i   (clock_i),
    .rst_b_i   (rst_b_i),
    .wr_i      (wr_wid),
    .wdata_i   (req_i.wdata[WID_W-1:0]), // R5 R8
    .load_i    (frame_start_i),
    .pending_o (pend_cfg.window_width),
    .live_o    (live_cfg.window_width)
  );

  shadow_field #(.W(HBLK_W), .RST_VALUE(RST_HORIZ_BLANK)) u_hblk
  (
    .clock_i   (clock_i),
    .rst_b_i   (rst_b_i),
    .wr_i      (wr_hblk),
    .wdata_i   (req_i.wdata[HBLK_W-1:0]), // R6 R8
    .load_i    (frame_start_i),
    .pending_o (pend_cfg.horizontal_blanking),
    .live_o    (live_cfg.horizontal_blanking)
  );

  shadow_field #(.W(VBLK_W), .RST_VALUE(RST_VERT_BLANK)) u_vblk
  (
    .clock_i   (clock_i),
    .rst_b_i   (rst_b_i),
    .wr_i      (wr_vblk),
    .wdata_i   (req_i.wdata[VBLK_W-1:0]), // R7 R8
    .load_i    (frame_start_i),
    .pending_o (pend_cfg.vertical_blanking),
    .live_o    (live_cfg.vertical_blanking)
  );

  // out-of-range values are passed through untouched; the host owns legality
  assign live_cfg_o = live_cfg; // R9

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] nxt_rdata;
  logic [DATA_W-1:0] rdata_ff;
  logic              rvalid_ff;

  // reads see pending copies only, undefined bits read as zero
  always_comb
  begin
    nxt_rdata = DATA_ZERO;
    case (req_i.addr)
      ADDR_CHIP_VERSION,
      ADDR_CHIP_VERSION_ALT: nxt_rdata = VERSION_ID;
      ADDR_COLUMN_START:     nxt_rdata[COL_W-1:0]  = pend_cfg.column_start;        // R10
      ADDR_ROW_START:        nxt_rdata[ROW_W-1:0]  = pend_cfg.row_start;           // R10
      ADDR_WINDOW_HEIGHT:    nxt_rdata[HGT_W-1:0]  = pend_cfg.window_height;       // R10
      ADDR_WINDOW_WIDTH:     nxt_rdata[WID_W-1:0]  = pend_cfg.window_width;        // R10
      ADDR_HORIZ_BLANK:      nxt_rdata[HBLK_W-1:0] = pend_cfg.horizontal_blanking; // R10
      ADDR_VERT_BLANK:       nxt_rdata[VBLK_W-1:0] = pend_cfg.vertical_blanking;   // R10
      default:               nxt_rdata = DATA_ZERO;
    endcase
  end

  always_ff @(posedge clock_i)
  begin
    if (!rst_b_i)
      rdata_ff <= DATA_ZERO;
    else if (req_i.rd_en)
      rdata_ff <= nxt_rdata;
  end

  always_ff @(posedge clock_i)
  begin
    if (!rst_b_i)
      rvalid_ff <= 1'b0;
    else
      rvalid_ff <= req_i.rd_en;
  end

  assign rdata_o  = rdata_ff;
  assign rvalid_o = rvalid_ff;

  // ----------------------------------------------------------------
  // frame start acknowledgement
  // ----------------------------------------------------------------
  // high in each cycle after a cycle with frame start, when the live copies have just been refreshed
  xfer_state_t state_ff;

  always_ff @(posedge clock_i)
  begin
    if (!rst_b_i)
      state_ff <= ST_IDLE;
    else
      case (state_ff)
        ST_IDLE:  state_ff <= frame_start_i ? ST_ARMED : ST_IDLE;
        ST_ARMED: state_ff <= frame_start_i ? ST_ARMED : ST_IDLE;
        default:  state_ff <= ST_IDLE;
      endcase
  end

  assign cfg_loaded_o = (state_ff == ST_ARMED);

endmodule

// File: tb/win_blank_asserts.sv
// checker for the window and blanking register set, bound onto the register block
// assumes one clock domain with a synchronous active-low reset
`timescale 1ns/1ns
module win_blank_asserts
  import win_blank_pkg::*;
#(
  parameter logic [15:0] VERSION_ID = VERSION_DEFAULT
)
(
  input wire logic        clock_i,
  input wire logic        rst_b_i,
  input wire reg_req_t    req_i,
  input wire logic [15:0] rdata_o,
  input wire logic        rvalid_o,
  input wire logic        frame_start_i,
  input wire window_cfg_t live_cfg_o,
  input wire logic        cfg_loaded_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);
  // ----------------------------------------
  // write followed by a load or a read back
  // ----------------------------------------
  sequence wr_to(a);
    req_i.wr_en && req_i.addr == a;
  endsequence
  property load_p(a, f, m);
    wr_to(a) ##1 (frame_start_i && !req_i.wr_en) |=> f == ($past(req_i.wdata, 2) & m);
  endproperty
  property back_p(a, m);
    wr_to(a) ##1 (req_i.rd_en && !req_i.wr_en && req_i.addr == a)
      |=> rdata_o == ($past(req_i.wdata, 2) & m);
  endproperty
  col_load_a:
    assert property (load_p(ADDR_COLUMN_START, live_cfg_o.column_start, 16'h03ff))
    else $error("column start not loaded");
  row_load_a:
    assert property (load_p(ADDR_ROW_START, live_cfg_o.row_start, 16'h01ff))
    else $error("row start not loaded");
  wid_load_a:
    assert property (load_p(ADDR_WINDOW_WIDTH, live_cfg_o.window_width, 16'h03ff))
    else $error("window width not loaded");
  vblk_load_a:
    assert property (load_p(ADDR_VERT_BLANK, live_cfg_o.vertical_blanking, 16'h7fff))
    else $error("vertical blanking not loaded");
  wid_back_a:
    assert property (back_p(ADDR_WINDOW_WIDTH, 16'h03ff)) else $error("width read back wrong");
  vblk_back_a:
    assert property (back_p(ADDR_VERT_BLANK, 16'h7fff)) else $error("blanking read back wrong");
  read_valid_a:
    assert property (rvalid_o == $past(req_i.rd_en)) else $error("read valid misplaced");
  load_flag_a:
    assert property (cfg_loaded_o == $past(frame_start_i)) else $error("load flag misplaced");
  live_hold_a:
    assert property (!frame_start_i |=> $stable(live_cfg_o)) else $error("live copy moved");
  version_read_a:
    assert property (req_i.rd_en && (req_i.addr == ADDR_CHIP_VERSION
      || req_i.addr == ADDR_CHIP_VERSION_ALT) |=> rdata_o == VERSION_ID)
    else $error("version read wrong");
endmodule

bind readout_window_blanking_regs win_blank_asserts #(.VERSION_ID(VERSION_ID)) u_chk (
  .clock_i(clock_i), .rst_b_i(rst_b_i), .req_i(req_i), .rdata_o(rdata_o), .rvalid_o(rvalid_o),
  .frame_start_i(frame_start_i), .live_cfg_o(live_cfg_o), .cfg_loaded_o(cfg_loaded_o));

// File: tb/host_model.sv
// host model on the register port of the window and blanking set
// assumes requests are taken on a rising edge and read data follows one cycle later
`timescale 1ns/1ns
module host_model
  import win_blank_pkg::*;
(
  input  wire logic        clock_i,
  output reg_req_t         req_o,
  input  wire logic [15:0] rdata_i,
  input  wire logic        rvalid_i
);
  initial req_o = '0;
  // ----------------------------------------
  // legal ranges: the device leaves anything else undefined, so it is never sent
  // ----------------------------------------
  function automatic bit legal(logic [7:0] a, logic [15:0] d);
    case (a)
      ADDR_COLUMN_START, ADDR_WINDOW_WIDTH: legal = d[9:0] != 10'h000 && d[9:0] <= 10'h2f0;
      ADDR_ROW_START: legal = d[8:0] >= 9'h004 && d[8:0] <= 9'h1e2;
      ADDR_WINDOW_HEIGHT: legal = d[8:0] != 9'h000 && d[8:0] <= 9'h1e0;
      ADDR_HORIZ_BLANK: legal = d[9:0] >= 10'h02b;
      ADDR_VERT_BLANK: legal = d[14:0] >= 15'h0004 && d[14:0] <= 15'h0bb8;
      default: legal = 1'b1;
    endcase
  endfunction
  // one assignment per falling edge, so back-to-back requests never collide
  task automatic put(input logic w, input logic r, input logic [7:0] a, input logic [15:0] d);
    @(negedge clock_i);
    req_o = '{w && legal(a, d), r, a, d};
  endtask
  task automatic get(output logic [15:0] d, output bit ok);
    put(1'b0, 1'b0, ~req_o.addr, ~req_o.wdata);
    ok = 1'b0;
    d = '0;
    repeat (4)
    begin
      if (!ok && rvalid_i === 1'b1)
      begin
        ok = 1'b1;
        d  = rdata_i;
      end
      if (!ok)
        @(negedge clock_i);
    end
  endtask
endmodule

// File: tb/tb.sv
// self-checking bench for the window and blanking register set
// assumes the host model drives the register port and the bench drives frame start
`timescale 1ns/1ns
module tb
  import win_blank_pkg::*;
();
  logic        clock_i = 1'b0;
  logic        rst_b_i = 1'b0;
  logic        frame_start = 1'b0;
  reg_req_t    req;
  logic [15:0] rdata;
  logic        rvalid;
  window_cfg_t live_cfg;
  logic        loaded;
  int          err_count = 0;
  int          checked = 0;
  logic [15:0] rv [1:6] = '{16'h0001, 16'h0004, 16'h01e0, 16'h02f0, 16'h005e, 16'h002d};
  logic [15:0] wv [1:6] = '{16'hfc05, 16'h81e2, 16'hfe01, 16'h0001, 16'h002b, 16'h8bb8};
  logic [15:0] mk [1:6] = '{16'h03ff, 16'h01ff, 16'h01ff, 16'h03ff, 16'h03ff, 16'h7fff};

  always #2 clock_i = ~clock_i;

  readout_window_blanking_regs u_dut (.clock_i(clock_i), .rst_b_i(rst_b_i), .req_i(req),
    .rdata_o(rdata), .rvalid_o(rvalid), .frame_start_i(frame_start), .live_cfg_o(live_cfg),
    .cfg_loaded_o(loaded));
  host_model u_host (.clock_i(clock_i), .req_o(req), .rdata_i(rdata), .rvalid_i(rvalid));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [15:0] lv(int i);
    case (i)
      1: lv = 16'(live_cfg.column_start);
      2: lv = 16'(live_cfg.row_start);
      3: lv = 16'(live_cfg.window_height);
      4: lv = 16'(live_cfg.window_width);
      5: lv = 16'(live_cfg.horizontal_blanking);
      default: lv = 16'(live_cfg.vertical_blanking);
    endcase
  endfunction
  task automatic stop_test();
    $display("checks %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(string n, logic [15:0] e, logic [15:0] s);
    checked++;
    if (s !== e)
    begin
      err_count++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic rchk(logic [7:0] a, logic [15:0] e);
    logic [15:0] d;
    bit          ok;
    u_host.put(1'b0, 1'b1, a, ~e);
    u_host.get(d, ok);
    if (!ok)
    begin
      err_count++;
      $display("Error rvalid expected 1 seen 0");
      stop_test();
    end
    else
      chk("rdata", e, d);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    for (int i = 1; i <= 6; i++)
    begin
      rchk(8'(i), rv[i]);
      chk("live reset", rv[i], lv(i));
    end
  endtask
  // range-end values except column start 5, undefined upper bits set for column, row, height and vertical blanking, each loaded by its own frame start
  task automatic t_shadow();
    for (int i = 1; i <= 6; i++)
    begin
      u_host.put(1'b1, 1'b0, 8'(i), wv[i]);
      rchk(8'(i), wv[i] & mk[i]);
      chk("live kept", rv[i], lv(i));
      u_host.put(1'b1, 1'b0, 8'(i), wv[i]);
      fork
        u_host.put(1'b0, 1'b0, 8'h00, ~wv[i]);
        begin
          @(negedge clock_i);
          frame_start = 1'b1;
        end
      join
      @(negedge clock_i);
      frame_start = 1'b0;
      chk("loaded", 16'h0001, 16'(loaded));
      chk("live", wv[i] & mk[i], lv(i));
    end
  endtask
  task automatic t_ro();
    u_host.put(1'b1, 1'b0, ADDR_CHIP_VERSION, 16'h0000);
    rchk(ADDR_CHIP_VERSION, VERSION_DEFAULT);
    rchk(ADDR_CHIP_VERSION_ALT, VERSION_DEFAULT);
    rchk(8'h40, 16'h0000);
  endtask
  // a reset in mid-run throws away both the pending and the live copies
  task automatic t_rerst();
    @(negedge clock_i);
    rst_b_i = 1'b0;
    repeat (2) @(negedge clock_i);
    rst_b_i = 1'b1;
    t_reset();
  endtask
  // a write that meets frame start waits for the next one; two starts in a row
  task automatic t_collide();
    fork
      u_host.put(1'b1, 1'b0, ADDR_WINDOW_HEIGHT, 16'h0100);
      begin
        @(negedge clock_i);
        frame_start = 1'b1;
      end
    join
    u_host.put(1'b0, 1'b0, 8'h00, 16'h0000);
    chk("live old", 16'(RST_WINDOW_HEIGHT), lv(3));
    @(negedge clock_i);
    frame_start = 1'b0;
    chk("live new", 16'h0100, lv(3));
    chk("loaded", 16'h0001, 16'(loaded));
  endtask

  initial
  begin
    repeat (10) @(negedge clock_i);
    rst_b_i = 1'b1;
    t_reset();
    t_shadow();
    t_ro();
    t_rerst();
    t_collide();
    stop_test();
  end
endmodule
